// ### pkg/mai_pkg.sv
// Constants for the multiplexed analog input word readout.
// Assumes one 250 MHz clock and an APB register port with 32-bit data.
// Notes on behaviour
// R1: Three index bits give the active channel in binary; all clear is channel 1.
// R2: Index bits update each controller scan and name that scan's presented channel.
// R3: Top word bit flags a broken transmitter on the indicated channel.
// R4: Missing field power or terminal block sets the flag and zeroes data; only field power is sensed here, there is no terminal block input.
// R5: Samples are unsigned 12-bit counts, bottom of range 0, top FFF.
// R6: Remote or pointerless controllers must read the word by per-scan multiplexing.
// R7: Pointer scheme needs per-slot channel-count and storage-pointer locations per base.
// R8: Controller samples the per-slot pointer settings only after a mode change.
// R9: Under multiplexing the controller keeps that slot's pointer locations at zero.
// R10: Pointer transfers convert each 12-bit count to BCD before storing.
// R11: Under multiplexing the controller uses the index bits to sort the data.
// R12: Conversion result sits in the low twelve bits, plain binary, bit 11 weighs 2048.
// R13: One enabled channel per scan, unused skipped, wrap to channel 1 after last.
// R14: Data, index and flag change together in one clock edge.
`default_nettype none
package mai_pkg;
    // Word layout.
    localparam int DATA_W        = 12;
    localparam int IDX_W         = 3;
    localparam int WORD_W        = 16;
    localparam int IDX_LSB       = 12;
    localparam int DIAG_BIT      = 15;
    localparam int CHAN_NUM      = 8;
    localparam logic [DATA_W-1:0] FULL_SCALE = 12'hFFF;
    localparam logic [DATA_W-1:0] ZERO_DATA  = 12'h000;
    localparam logic [IDX_W-1:0]  FIRST_CHAN = 3'h0;
    localparam logic [IDX_W-1:0]  IDX_ONE    = 3'h1;
    // Register map, byte offsets.
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_OFF    = 12'h000;
    localparam logic [ADDR_W-1:0] WORD_OFF    = 12'h004;
    localparam logic [ADDR_W-1:0] INTSTAT_OFF = 12'h008;
    localparam logic [ADDR_W-1:0] INTMASK_OFF = 12'h00C;
    // Control field: index of the last enabled channel, reset to all eight.
    localparam logic [IDX_W-1:0] LAST_CHAN_RST = 3'h7;
    // Interrupt bits.
    localparam int INT_W        = 3;
    localparam int INT_UPDATE   = 0;
    localparam int INT_DIAG     = 1;
    localparam int INT_POWER    = 2;
    localparam logic [INT_W-1:0] INT_RST = 3'h0;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : mai_pkg
`default_nettype wire

// ### verilog/mai_sync.sv
// Two-flop synchroniser for pin-level inputs.
// Assumes inputs are levels that change slowly against mclk.
`default_nettype none
module mai_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Levels.
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second, so metastability stays contained.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule : mai_sync
`default_nettype wire

// ### verilog/mai_chan_seq.sv
// Channel sequencer: steps through the enabled channels once per scan.
// Assumes advance is a one-cycle pulse on mclk.
`default_nettype none
module mai_chan_seq #(
    parameter int IDX_W = mai_pkg::IDX_W
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Control.
    input  wire logic             advance,
    input  wire logic [IDX_W-1:0] lastChan,
    // Current channel.
    output var  logic [IDX_W-1:0] curChan
);
    logic [IDX_W-1:0] next_curChan;

    // Unused channels are never stepped into; a count lowered below the current channel wraps at the next advance.
    assign next_curChan = (curChan >= lastChan) ? mai_pkg::FIRST_CHAN
                                                : curChan + mai_pkg::IDX_ONE; // R13

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            curChan <= mai_pkg::FIRST_CHAN;
        end else if (advance) begin
            curChan <= next_curChan; // R13
        end
    end
endmodule : mai_chan_seq
`default_nettype wire

// ### verilog/mai_readout.sv
// Top of the analog input word readout: sample store, word latch, APB registers.
// Assumes the converter side delivers samples on mclk and the scan strobe,
// fault pins and field power sense arrive asynchronously from pins.
`default_nettype none
module mai_readout #(
    parameter int ADDR_W = mai_pkg::ADDR_W,
    parameter int DATA_W = mai_pkg::DATA_W,
    parameter int IDX_W  = mai_pkg::IDX_W,
    parameter int CHAN_N = mai_pkg::CHAN_NUM
) (
    // Clock and reset.
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    // APB slave.
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [31:0]              pwdata,
    output var  logic [31:0]              prdata,
    output var  logic                     pready,
    output var  logic                     pslverr,
    // Converter results, same clock.
    input  wire logic                     convValid,
    input  wire logic [IDX_W-1:0]         convChannel,
    input  wire logic [DATA_W-1:0]        convData,
    // Pins from the field side and the controller.
    input  wire logic                     scanStrobe,
    input  wire logic [CHAN_N-1:0]        xmtrBroken,
    input  wire logic                     fieldPowerOk,
    // Word seen by the controller and interrupt.
    output var  logic [mai_pkg::WORD_W-1:0] moduleUpperInputWord,
    output var  logic                     irq
);
    // Synchronised pin levels.
    logic [CHAN_N:0]      pinSync;
    logic                 scanSync;
    logic                 scanSyncDly;
    logic                 powerOkDly;
    wire  [CHAN_N-1:0]    brokenSync = pinSync[CHAN_N-1:0];
    wire                  powerOkSync = pinSync[CHAN_N];

    // Sample store and sequencer.
    logic [DATA_W-1:0]    sampleMem [CHAN_N];
    logic [IDX_W-1:0]     seqChan;
    logic [IDX_W-1:0]     lastChan;

    // Interrupt state.
    logic [mai_pkg::INT_W-1:0] intStatus;
    logic [mai_pkg::INT_W-1:0] intMask;

    // Scan and power edges from the synchronised levels; declared before the sequencer uses them.
    // Only the second synchroniser stage and its delayed copy are read here.
    wire scanTick  = scanSync & ~scanSyncDly;
    wire powerLost = ~powerOkSync;
    wire powerFall = powerOkDly & ~powerOkSync;

    mai_sync #(
        .WIDTH   (CHAN_N + 1)
    ) u_pinSync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .asyncIn ({fieldPowerOk, xmtrBroken}),
        .syncOut (pinSync)
    );

    mai_sync #(
        .WIDTH   (1)
    ) u_scanSync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .asyncIn (scanStrobe),
        .syncOut (scanSync)
    );

    mai_chan_seq #(
        .IDX_W    (IDX_W)
    ) u_seq (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .advance  (scanTick),
        .lastChan (lastChan),
        .curChan  (seqChan)
    );

    // Delayed copies for the edge detectors; they reset like their synchronisers,
    // so no false scan or power edge follows the release of reset.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scanSyncDly <= 1'b0;
            powerOkDly  <= 1'b0;
        end else begin
            scanSyncDly <= scanSync;
            powerOkDly  <= powerOkSync;
        end
    end

    // The converter runs freely; the newest result per channel is kept here.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < CHAN_N; i++) begin
                sampleMem[i] <= mai_pkg::ZERO_DATA;
            end
        end else if (convValid) begin
            sampleMem[convChannel] <= convData; // R5
        end
    end

    // Word content for the channel presented at this scan.
    wire [DATA_W-1:0] selData     = sampleMem[seqChan];
    wire              brokenSel   = brokenSync[seqChan];
    wire [DATA_W-1:0] presentData = powerLost ? mai_pkg::ZERO_DATA : selData; // R4
    wire              next_diag   = brokenSel | powerLost; // R3 R4
    wire [mai_pkg::WORD_W-1:0] next_word = {next_diag, seqChan, presentData}; // R1 R12

    // Data, index and flag are latched in one register so the controller
    // can never pair one channel's data with another channel's index.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            moduleUpperInputWord <= '0;
        end else if (scanTick) begin
            moduleUpperInputWord <= next_word; // R2 R14
        end
    end

    // Register decode. Offsets are compared whole, so a misaligned address misses every register.
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
        return addr == offset;
    endfunction : addr_hit

    wire apbSetup  = psel & ~penable;
    wire apbAccess = psel & penable;
    wire apbDone   = apbAccess & pready;
    wire selCtrl   = addr_hit(paddr, mai_pkg::CTRL_OFF);
    wire selWord   = addr_hit(paddr, mai_pkg::WORD_OFF);
    wire selStat   = addr_hit(paddr, mai_pkg::INTSTAT_OFF);
    wire selMask   = addr_hit(paddr, mai_pkg::INTMASK_OFF);
    wire selAny    = selCtrl | selWord | selStat | selMask;
    wire wrStrobe  = apbDone & pwrite & selAny;
    wire [IDX_W-1:0] wrChan = pwdata[IDX_W-1:0];
    wire [mai_pkg::INT_W-1:0] statClr = (wrStrobe & selStat) ? pwdata[mai_pkg::INT_W-1:0]
                                                              : mai_pkg::INT_RST;

    // Read mux; unmapped addresses read zero and raise pslverr.
    wire [31:0] rdMux =
        selCtrl ? {{(32-IDX_W){1'b0}}, lastChan} :
        selWord ? {{(32-mai_pkg::WORD_W){1'b0}}, moduleUpperInputWord} :
        selStat ? {{(32-mai_pkg::INT_W){1'b0}}, intStatus} :
        selMask ? {{(32-mai_pkg::INT_W){1'b0}}, intMask} :
                  mai_pkg::ZERO_WORD;

    // One wait state: pready rises in the second access cycle with registered data,
    // which keeps every bus output straight from a flop.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= mai_pkg::ZERO_WORD;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbAccess & ~pready;
            prdata  <= (apbAccess & ~pready & ~pwrite) ? rdMux : mai_pkg::ZERO_WORD;
            pslverr <= apbAccess & ~pready & ~selAny;
        end
    end

    // Control and mask writes.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lastChan <= mai_pkg::LAST_CHAN_RST;
            intMask  <= mai_pkg::INT_RST;
        end else if (wrStrobe) begin
            if (selCtrl) begin
                lastChan <= wrChan;
            end
            if (selMask) begin
                intMask <= pwdata[mai_pkg::INT_W-1:0];
            end
        end
    end

    // Sticky events; a set in the same cycle as a write-one clear wins.
    wire [mai_pkg::INT_W-1:0] intSet = {powerFall,
                                        scanTick & next_diag & ~moduleUpperInputWord[mai_pkg::DIAG_BIT],
                                        scanTick};
    wire [mai_pkg::INT_W-1:0] next_intStatus = (intStatus & ~statClr) | intSet;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            intStatus <= mai_pkg::INT_RST;
            irq       <= 1'b0;
        end else begin
            intStatus <= next_intStatus;
            irq       <= |(next_intStatus & intMask);
        end
    end

    // Checks on the word the controller sees and on the channel sequencer.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_index_binary: assert property ( // R1
        scanTick |=> moduleUpperInputWord[mai_pkg::IDX_LSB +: IDX_W] == $past(seqChan))
        else $error("Index bits do not match the presented channel.");

    chk_index_scan: assert property ( // R2
        scanTick |-> ##1 seqChan != $past(seqChan) || lastChan == mai_pkg::FIRST_CHAN)
        else $error("Channel did not advance on a scan.");

    chk_diag_broken: assert property ( // R3
        scanTick && brokenSel |=> moduleUpperInputWord[mai_pkg::DIAG_BIT])
        else $error("Broken transmitter not flagged.");

    chk_diag_quiet: assert property ( // R3
        scanTick && !brokenSel && !powerLost |=> !moduleUpperInputWord[mai_pkg::DIAG_BIT])
        else $error("Fault flag set without a cause.");

    chk_power_zero: assert property ( // R4
        scanTick && powerLost |=> moduleUpperInputWord[DATA_W-1:0] == mai_pkg::ZERO_DATA
                                  && moduleUpperInputWord[mai_pkg::DIAG_BIT])
        else $error("Power loss did not zero data and set the flag.");

    chk_full_scale: assert property ( // R5
        scanTick && !powerLost && selData == mai_pkg::FULL_SCALE
        |=> moduleUpperInputWord[DATA_W-1:0] == mai_pkg::FULL_SCALE)
        else $error("Full scale count not presented.");

    chk_data_low: assert property ( // R12
        scanTick |=> moduleUpperInputWord[DATA_W-1:0] == $past(presentData))
        else $error("Data bits are not the stored sample.");

    chk_seq_wrap: assert property ( // R13
        scanTick && seqChan >= lastChan |=> seqChan == mai_pkg::FIRST_CHAN)
        else $error("Sequencer did not wrap to channel one.");

    chk_seq_step: assert property ( // R13
        scanTick && seqChan < lastChan |=> seqChan == $past(seqChan) + mai_pkg::IDX_ONE)
        else $error("Sequencer skipped an enabled channel.");

    chk_word_atomic: assert property ( // R14
        !scanTick |=> $stable(moduleUpperInputWord))
        else $error("Word changed outside a scan.");

    chk_seq_hold: assert property ( // R2
        !scanTick |=> $stable(seqChan))
        else $error("Channel moved between scans.");

    // Event checks: every event reaches its sticky bit at the edge after it,
    // and the update bit stays set while it is not cleared.
    chk_power_event: assert property ( // R4
        powerFall |=> intStatus[mai_pkg::INT_POWER])
        else $error("Field power loss not recorded.");

    chk_update_event: assert property ( // R2
        scanTick |=> intStatus[mai_pkg::INT_UPDATE])
        else $error("Scan update not recorded.");

    chk_diag_event: assert property ( // R3
        scanTick && next_diag && !moduleUpperInputWord[mai_pkg::DIAG_BIT] |=> intStatus[mai_pkg::INT_DIAG])
        else $error("Rising fault flag not recorded.");

    chk_sticky_hold: assert property (
        intStatus[mai_pkg::INT_UPDATE] && !statClr[mai_pkg::INT_UPDATE] |=> intStatus[mai_pkg::INT_UPDATE])
        else $error("Sticky bit lost without a clear.");

    chk_irq_level: assert property (
        $stable(intMask) |-> irq == (|(intStatus & intMask)))
        else $error("Interrupt level does not follow status and mask.");

    // Bus checks: exactly one wait state, a one-cycle answer, read data only with it.
    // Unmapped addresses are refused without touching any register.
    chk_ready_wait: assert property (
        apbAccess && !pready |=> pready)
        else $error("Access not answered after one wait state.");

    chk_ready_pulse: assert property (
        pready |=> !pready)
        else $error("Ready held longer than one cycle.");

    chk_setup_quiet: assert property (
        apbSetup |-> !pready && !pslverr)
        else $error("Answer given in a setup cycle.");

    chk_rdata_idle: assert property (
        !pready |-> prdata == mai_pkg::ZERO_WORD)
        else $error("Read data shown outside an answer.");

    chk_slverr_map: assert property (
        apbAccess && !pready && !selAny |=> pslverr)
        else $error("Unmapped address not refused.");

    chk_unmapped_ignored: assert property (
        apbDone && pwrite && !selAny |=> $stable(lastChan) && $stable(intMask))
        else $error("Write to an unmapped address changed a register.");

    chk_ctrl_write: assert property ( // R13
        wrStrobe && selCtrl |=> lastChan == $past(wrChan))
        else $error("Channel count write did not land.");

    // Main scenarios.
    cov_wrap:     cover property (scanTick && seqChan == lastChan && lastChan != mai_pkg::FIRST_CHAN);
    cov_power:    cover property (scanTick && powerLost);
    cov_broken:   cover property (scanTick && brokenSel && !powerLost);
    cov_irq:      cover property ($rose(irq));
    cov_w1c:      cover property (wrStrobe && selStat && (|intStatus));
endmodule : mai_readout
`default_nettype wire

// ### test/mai_cpu_model.sv
// Controller model: makes the scan strobe and files the shared word by channel.
// Assumes the readout top drives the word and scans come only from do_scan.
`default_nettype none
module mai_cpu_model (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Module word and scan pin.
    input  wire logic [15:0] moduleUpperInputWord,
    output var  logic        scanStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pointer locations stay zero, so only the scan word carries data.
    logic [15:0] slot0ChannelCountLoc     = 16'h0000;
    logic [15:0] slot0StoragePointerLoc   = 16'h0000;
    logic [15:0] exp1Slot0ChannelCountLoc = 16'h0000;
    // Copies taken at a mode change; edits made within one mode never reach them.
    logic [15:0] latchedCount    = 16'h0000;
    logic [15:0] latchedPointer  = 16'h0000;
    logic [15:0] latchedExpCount = 16'h0000;
    logic [11:0] sortedData [8];
    logic        sortedFlag [8];
    logic [15:0] pointerStore [8];
    initial scanStrobe = 1'b0;
    // Mode transition: the only moment at which the pointer settings are read.
    task automatic mode_change();
        latchedCount    = slot0ChannelCountLoc;
        latchedPointer  = slot0StoragePointerLoc;
        latchedExpCount = exp1Slot0ChannelCountLoc;
    endtask : mode_change
    // Binary count to four BCD digits, as a pointer transfer stores it.
    function automatic logic [15:0] to_bcd(input logic [11:0] b);
        return {4'(b / 1000), 4'((b / 100) % 10), 4'((b / 10) % 10), 4'(b % 10)};
    endfunction : to_bcd
    // One scan: strobe held four cycles so the pin sync cannot miss it, then the word is filed.
    task automatic do_scan();
        @(posedge mclk) scanStrobe <= 1'b1;
        repeat (4) @(posedge mclk);
        scanStrobe <= 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        if (latchedCount != 16'h0000) begin
            pointerStore[moduleUpperInputWord[14:12]] = to_bcd(moduleUpperInputWord[11:0]);
        end else begin
            sortedData[moduleUpperInputWord[14:12]] = moduleUpperInputWord[11:0];
            sortedFlag[moduleUpperInputWord[14:12]] = moduleUpperInputWord[15];
        end
    endtask : do_scan
endmodule : mai_cpu_model
`default_nettype wire

// ### test/tb_multiplexed_analog_input_word.sv
// Self-checking bench for the analog input word readout.
// Assumes the readout top, the package and the controller model are compiled first.
`default_nettype none
module tb_multiplexed_analog_input_word;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, irq, scanStrobe;
    logic convValid = 1'b0, fieldPowerOk = 1'b1;
    logic [2:0] convChannel = 3'h0, expChan = 3'h0, lastChan = 3'h7;
    logic [11:0] convData = 12'h000;
    logic [7:0] xmtrBroken = 8'h00;
    logic [15:0] moduleUpperInputWord;
    logic [15:0] expWord = 16'h0000;
    logic [11:0] expData [8];
    int errCount = 0, checksDone = 0;
    // Clock at 250 MHz.
    always #2 mclk = ~mclk;
    mai_readout mai_readout_inst (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convValid(convValid), .convChannel(convChannel), .convData(convData),
        .scanStrobe(scanStrobe), .xmtrBroken(xmtrBroken), .fieldPowerOk(fieldPowerOk),
        .moduleUpperInputWord(moduleUpperInputWord), .irq(irq));
    mai_cpu_model mai_cpu_model_inst (.mclk(mclk), .reset_n(reset_n),
        .moduleUpperInputWord(moduleUpperInputWord), .scanStrobe(scanStrobe));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : cmp32
    task automatic cmp1(input string what, input logic e, input logic g);
        cmp32(what, {31'h0, e}, {31'h0, g});
    endtask : cmp1
    // APB transfer; the answer is taken at the edge where pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // No cycle count is assumed; the watchdog ends a wait that is never answered.
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic load(input logic [2:0] c, input logic [11:0] d);
        @(posedge mclk);
        convValid <= 1'b1; convChannel <= c; convData <= d;
        @(posedge mclk);
        convValid <= 1'b0;
        expData[c] = d;
    endtask : load
    function automatic logic [2:0] next_chan(input logic [2:0] c, input logic [2:0] last);
        return (c >= last) ? 3'h0 : c + 3'h1;
    endfunction : next_chan
    // One scan; the expected word is built from what was loaded and the pin levels.
    task automatic scan_chk();
        logic [15:0] e;
        mai_cpu_model_inst.do_scan();
        // Pins stand through the scan, so the expectation is built once they have settled.
        e = {xmtrBroken[expChan] | ~fieldPowerOk, expChan, fieldPowerOk ? expData[expChan] : 12'h000};
        expWord = e;
        cmp32("word", {16'h0, e}, {16'h0, moduleUpperInputWord});
        cmp32("filed", {20'h0, e[11:0]}, {20'h0, mai_cpu_model_inst.sortedData[expChan]});
        cmp1("filed flag", e[15], mai_cpu_model_inst.sortedFlag[expChan]);
        expChan = next_chan(expChan, lastChan);
    endtask : scan_chk
    // Watchdog sized well above the expected run of about 300 cycles.
    initial begin
        #200000;
        errCount++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h6d3c7742));
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        mai_cpu_model_inst.mode_change();
        cmp32("pointer locs", 32'h0000_0000, {mai_cpu_model_inst.latchedCount, mai_cpu_model_inst.latchedPointer});
        cmp32("exp count loc", 32'h0000_0000, {16'h0000, mai_cpu_model_inst.latchedExpCount});
        // A refused write must leave the control register at its reset value.
        apb(1'b1, 12'h010, 32'h0000_0005);
        cmp1("unmapped wr err", 1'b1, err);
        apb(1'b0, mai_pkg::CTRL_OFF, 32'h0);
        cmp32("ctrl reset", 32'h0000_0007, rd);
        apb(1'b0, mai_pkg::INTMASK_OFF, 32'h0);
        cmp32("mask reset", 32'h0000_0000, rd);
        apb(1'b0, 12'h010, 32'h0);
        cmp1("unmapped err", 1'b1, err);
        cmp32("unmapped data", 32'h0000_0000, rd);
        // Extremes of the count range on the first and last channel.
        load(3'h0, 12'h000);
        load(3'h7, mai_pkg::FULL_SCALE);
        for (int i = 1; i < 7; i++) load(3'(i), 12'($urandom));
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            xmtrBroken <= 8'($urandom);
            scan_chk();
            if (i == 4) load(3'($urandom), 12'($urandom));
        end
        apb(1'b0, mai_pkg::WORD_OFF, 32'h0);
        cmp32("word read", {16'h0, expWord}, rd);
        // Fewer channels: the wrap follows the last enabled index.
        foreach (expData[k]) begin
            if (k == 2 || k == 0) begin
                lastChan = 3'(k);
                apb(1'b1, mai_pkg::CTRL_OFF, {29'h0, lastChan});
                repeat (4) scan_chk();
            end
        end
        // Field power lost: flag set and data zero.
        lastChan = 3'h7;
        apb(1'b1, mai_pkg::CTRL_OFF, 32'h0000_0007);
        fieldPowerOk <= 1'b0;
        repeat (4) @(posedge mclk);
        repeat (2) scan_chk();
        apb(1'b0, mai_pkg::INTSTAT_OFF, 32'h0);
        cmp1("power fell", 1'b1, rd[mai_pkg::INT_POWER]);
        fieldPowerOk <= 1'b1;
        repeat (4) @(posedge mclk);
        // Interrupt: masked in, raised by a scan, cleared by writing one.
        apb(1'b1, mai_pkg::INTSTAT_OFF, 32'h0000_0007);
        apb(1'b1, mai_pkg::INTMASK_OFF, 32'h0000_0001);
        repeat (3) @(posedge mclk);
        cmp1("irq idle", 1'b0, irq);
        scan_chk();
        cmp1("irq set", 1'b1, irq);
        apb(1'b1, mai_pkg::INTSTAT_OFF, 32'h0000_0001);
        repeat (3) @(posedge mclk);
        cmp1("irq clear", 1'b0, irq);
        report_and_stop();
    end
endmodule : tb_multiplexed_analog_input_word
`default_nettype wire
